// File: src/exec_params.svh
/*
 * Constants for the set-all-ones and low-power halt execution block.
 * Assumes a single core clock and a four-phase instruction cycle.
 */
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ==========================================================
// Opcode fields
`define OP_FILL_HI      7'h34
`define OP_HALT_WORD    16'h0003
`define ALL_ONES        8'hFF

// ==========================================================
// Addressing
`define IDX_LIMIT       8'h5F
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF

// ==========================================================
// Reset values
`define PWR_DOWN_RESET  1'h1
`define TIMEOUT_RESET   1'h1

`endif

// File: src/exec_pkg.sv
/*
 * Types for the execution block.
 * Assumes the constants header is included by users.
 */
package exec_pkg;

    // Quarter-cycle phase, Gray coded along Q1-Q2-Q3-Q4
    typedef enum logic [1:0] {
        Q1 = 2'h0,
        Q2 = 2'h1,
        Q3 = 2'h3,
        Q4 = 2'h2
    } phase_t;

    typedef enum logic [1:0] {
        RUN   = 2'h0,
        HALT  = 2'h1,
        WAKE  = 2'h3
    } run_t;

    typedef struct packed {
        phase_t      phase;
        run_t        run;
        logic [15:0] instr;
        logic        is_fill;
        logic        is_halt;
        logic [11:0] addr;
        logic        wr_en;
        logic [11:0] wr_addr;
        logic [7:0]  wr_data;
        logic        power_down_flag;
        logic        timeout_flag;
        logic        watchdog_clr;
        logic        osc_run;
        logic        busy;
        logic        wake_s1;
        logic        wake_s2;
        logic        expiry_s1;
        logic        expiry_s2;
    } state_t;

endpackage

// File: src/exec_unit.sv
/*
 * Execution of the set-all-ones and low-power halt instructions.
 * Assumes the decoder presents one instruction word per four-phase
 * instruction cycle on instr_valid, and that wake sources are asynchronous pins.
 */
`timescale 1ns/1ps
`include "exec_params.svh"

// Functional notes
// - Set-all-ones writes FFh to the addressed file register.
// - Bank bit 0 picks the common bank, bank bit 1 the bank-select value.
// - Bank bit 0 with extended set uses indexed offset for f up to 5Fh.
// - The halt instruction clears the power-down flag.
// - The halt instruction sets the time-out flag.
// - The halt instruction resets the watchdog counter and postscaler.
// - After its cycle halt stops the core and the oscillator.
// - Waking by watchdog expiry clears the time-out flag.
module exec_unit (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Instruction from decoder
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic [11:0] fsr2_base,
    // Wake sources (asynchronous)
    input  wire logic        wake_event,
    input  wire logic        watchdog_expired,
    // File register write port
    output logic             wr_en,
    output logic [11:0]      wr_addr,
    output logic [7:0]       wr_data,
    // Status and control
    output logic             power_down_flag,
    output logic             timeout_flag,
    output logic             watchdog_clear,
    output logic             osc_run,
    output logic             busy
);

    exec_pkg::state_t s_q;
    exec_pkg::state_t s_d;

    // ==========================================================
    // Next state
    always_comb begin
        s_d         = s_q;
        s_d.wr_en   = 1'b0;
        s_d.watchdog_clr = 1'b0;
        s_d.wake_s1      = wake_event;
        s_d.wake_s2      = s_q.wake_s1;
        s_d.expiry_s1    = watchdog_expired;
        s_d.expiry_s2    = s_q.expiry_s1;
        case (s_q.run)
            exec_pkg::RUN: begin
                case (s_q.phase)
                    exec_pkg::Q1: begin
                        if (instr_valid) begin
                            s_d.instr   = instr_word;
                            s_d.is_fill = (instr_word[15:9] == `OP_FILL_HI);
                            s_d.is_halt = (instr_word == `OP_HALT_WORD);
                            s_d.phase   = exec_pkg::Q2;
                        end
                    end
                    exec_pkg::Q2: begin
                        if (!s_q.instr[8]) begin
                            if (ext_set_en
                                && s_q.instr[7:0] <= `IDX_LIMIT) begin
                                s_d.addr = fsr2_base
                                    + {4'h0, s_q.instr[7:0]};
                            end else if (s_q.instr[7:0] < `ACCESS_SPLIT) begin
                                s_d.addr = {4'h0, s_q.instr[7:0]};
                            end else begin
                                s_d.addr = {`ACCESS_HI_BANK,
                                            s_q.instr[7:0]};
                            end
                        end else begin
                            s_d.addr = {bank_select_reg,
                                        s_q.instr[7:0]};
                        end
                        s_d.phase = exec_pkg::Q3;
                    end
                    exec_pkg::Q3: begin
                        if (s_q.is_halt) begin
                            s_d.power_down_flag = 1'b0;
                            s_d.timeout_flag    = 1'b1;
                            s_d.watchdog_clr    = 1'b1;
                        end
                        s_d.phase = exec_pkg::Q4;
                    end
                    exec_pkg::Q4: begin
                        if (s_q.is_fill) begin
                            s_d.wr_en   = 1'b1;
                            s_d.wr_addr = s_q.addr;
                            s_d.wr_data = `ALL_ONES;
                        end
                        if (s_q.is_halt) begin
                            s_d.run     = exec_pkg::HALT;
                            s_d.osc_run = 1'b0;
                        end
                        s_d.is_fill = 1'b0;
                        s_d.is_halt = 1'b0;
                        s_d.phase   = exec_pkg::Q1;
                    end
                    default: s_d.phase = exec_pkg::Q1;
                endcase
            end
            exec_pkg::HALT: begin
                if (s_q.expiry_s2) begin
                    s_d.timeout_flag = 1'b0;
                    s_d.run          = exec_pkg::WAKE;
                end else if (s_q.wake_s2) begin
                    s_d.run = exec_pkg::WAKE;
                end
            end
            exec_pkg::WAKE: begin
                s_d.osc_run = 1'b1;
                s_d.run     = exec_pkg::RUN;
                s_d.phase   = exec_pkg::Q1;
            end
            default: s_d.run = exec_pkg::RUN;
        endcase
        // Busy is registered so the port comes from a flop
        s_d.busy = (s_d.run != exec_pkg::RUN);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q                 <= '0;
            s_q.phase           <= exec_pkg::Q1;
            s_q.run             <= exec_pkg::RUN;
            s_q.power_down_flag <= `PWR_DOWN_RESET;
            s_q.timeout_flag    <= `TIMEOUT_RESET;
            s_q.osc_run         <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign wr_en           = s_q.wr_en;
    assign wr_addr         = s_q.wr_addr;
    assign wr_data         = s_q.wr_data;
    assign power_down_flag = s_q.power_down_flag;
    assign timeout_flag    = s_q.timeout_flag;
    assign watchdog_clear  = s_q.watchdog_clr;
    assign osc_run         = s_q.osc_run;
    assign busy            = s_q.busy;

endmodule

// File: tb/exec_unit_checker.sv
/* Port checker for exec_unit.
 * Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module exec_unit_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Observed ports
    input wire logic [15:0] instr_word,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_data,
    input wire logic        power_down_flag,
    input wire logic        timeout_flag,
    input wire logic        watchdog_clear,
    input wire logic        osc_run,
    input wire logic        busy
);
    // =====
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_fill_data: assert property (
        wr_en |-> wr_data == 8'hFF) else $error("fill data wrong");
    a_wr_pulse: assert property (
        wr_en |=> !wr_en) else $error("write pulse too long");
    a_flag_hold: assert property (
        wr_en |-> $stable(power_down_flag) && $stable(timeout_flag))
        else $error("flags moved on fill");
    a_halt_cause: assert property (
        watchdog_clear |-> $past(instr_word, 3) == 16'h0003)
        else $error("clear without halt");
    a_halt_flags: assert property (
        watchdog_clear |-> !power_down_flag && timeout_flag)
        else $error("halt flags wrong");
    a_clr_pulse: assert property (
        watchdog_clear |=> !watchdog_clear)
        else $error("clear pulse too long");
    a_osc_stop: assert property (
        watchdog_clear |=> !osc_run && busy)
        else $error("oscillator not stopped");
    a_wake_clear: assert property (
        $fell(timeout_flag) |-> busy ##1 (osc_run && !busy))
        else $error("timeout flag fell outside wake");
endmodule
bind exec_unit exec_unit_checker i_chk (.clk, .arst_n, .instr_word, .wr_en,
    .wr_data, .power_down_flag, .timeout_flag, .watchdog_clear, .osc_run,
    .busy);

// File: tb/tb_set_file_and_low_power_entry_ops.sv
/* Directed bench for exec_unit.
 * Assumes exec_unit and its checker are compiled first. */
`timescale 1ns/1ps
module tb_set_file_and_low_power_entry_ops;
    // =====
    // Signals
    logic        clk, arst_n, instr_valid, ext_set_en, wake_event;
    logic        watchdog_expired, wr_en, power_down_flag, timeout_flag;
    logic        watchdog_clear, osc_run, busy;
    logic [15:0] instr_word;
    logic [3:0]  bank_select_reg;
    logic [11:0] fsr2_base, wr_addr;
    logic [7:0]  wr_data;
    int          fail_count = 0, samples_checked = 0, cyc = 0;

    exec_unit i_dut (.clk, .arst_n, .instr_valid, .instr_word, .ext_set_en,
        .bank_select_reg, .fsr2_base, .wake_event, .watchdog_expired, .wr_en,
        .wr_addr, .wr_data, .power_down_flag, .timeout_flag, .watchdog_clear,
        .osc_run, .busy);

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    // =====
    // Tasks
    task chk(input string n, input logic [11:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task fill(input logic [15:0] w, input logic x, input logic [3:0] b,
              input logic [11:0] ea, input logic ee);
        logic pd;
        pd = power_down_flag;
        instr_valid <= 1'h1;
        instr_word <= w;
        ext_set_en <= x;
        bank_select_reg <= b;
        @(posedge clk) instr_valid <= 1'h0;
        repeat (3) @(posedge clk);
        #1 chk("wr_en", wr_en, ee);
        if (ee) chk("wr_addr", wr_addr, ea);
        if (ee) chk("wr_data", wr_data, 12'h0FF);
        chk("power_down_flag", power_down_flag, pd);
        repeat (3) @(posedge clk);
    endtask

    task halt(input logic by_wdt);
        int n;
        instr_valid <= 1'h1;
        instr_word <= 16'h0003;
        @(posedge clk) instr_valid <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk("power_down_flag", power_down_flag, 1'h0);
        chk("timeout_flag", timeout_flag, 1'h1);
        chk("watchdog_clear", watchdog_clear, 1'h1);
        @(posedge clk) #1 chk("osc", osc_run, 1'h0);
        repeat (3) @(posedge clk);
        #1 chk("busy", busy, 1'h1);
        @(posedge clk);
        if (by_wdt) watchdog_expired <= 1'h1;
        else wake_event <= 1'h1;
        n = 0;
        while (busy !== 1'h0 && n < 20) begin
            @(posedge clk) #1 n++;
        end
        chk("osc", osc_run, 1'h1);
        chk("timeout_flag", timeout_flag, !by_wdt);
        @(posedge clk);
        watchdog_expired <= 1'h0;
        wake_event <= 1'h0;
    endtask

    // =====
    // Sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            stop_test;
        end
    end

    initial begin
        arst_n = 0;
        instr_valid = 0;
        instr_word = 16'h0000;
        ext_set_en = 0;
        bank_select_reg = 4'h0;
        fsr2_base = 12'h120;
        wake_event = 0;
        watchdog_expired = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        fill(16'h6905, 1'h0, 4'h3, 12'h305, 1'h1);
        fill(16'h69FF, 1'h1, 4'hA, 12'hAFF, 1'h1);
        fill(16'h685F, 1'h0, 4'h3, 12'h05F, 1'h1);
        fill(16'h6860, 1'h0, 4'h3, 12'hF60, 1'h1);
        fill(16'h685F, 1'h1, 4'h3, 12'h17F, 1'h1);
        fill(16'h6860, 1'h1, 4'h3, 12'hF60, 1'h1);
        fill(16'h6A05, 1'h0, 4'h3, 12'h000, 1'h0);
        halt(1'h1);
        fill(16'h6800, 1'h0, 4'h3, 12'h000, 1'h1);
        halt(1'h0);
        stop_test;
    end
endmodule
